// [logic/sre_fifo.sv]
// Parameterised valid/ready FIFO for received characters.
`timescale 1ns/1ps
`default_nettype none
module sre_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic flush,
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
    logic [AW:0] count, next_count;
    logic push, pop;

    // ----------------------------------------
    // Pointer and count update
    // ----------------------------------------
    always_comb begin
        push = in_valid && in_ready;
        pop = out_valid && out_ready;
        next_wr_ptr = push ? AW'(wr_ptr + 1'b1) : wr_ptr;
        next_rd_ptr = pop ? AW'(rd_ptr + 1'b1) : rd_ptr;
        next_count = (AW+1)'(count + push - pop);
        if (flush) begin
            next_wr_ptr = '0;
            next_rd_ptr = '0;
            next_count = '0;
        end
    end

    // Storage is written without reset; only pointers and count need a known value.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            count <= next_count;
        end
    end

    always_ff @(posedge pclk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    assign in_ready = (count != (AW+1)'(DEPTH));
    assign out_valid = (count != '0);
    assign out_data = mem[rd_ptr];
endmodule : sre_fifo
`default_nettype wire

// [logic/sre_rx.sv]
// Serial receiver with overrun and framing error flags on an APB slave.
//
// The APB slave port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "sre_cfg.svh"
// Overview of operation
// - Overrun flag at status bit 5, resets 0.
// - Framing flag at status bit 4, resets 0.
// - Receive disable leaves both error flags unchanged.
// - Reset or standby forces both flags to 0.
// - Overrun clears only by read 1, write 0.
// - Framing clears only by read 1, write 0.
// - Overrun keeps held character, discards new ones.
// - No reception while overrun flag set.
// - Stop bit sampled 0 sets framing flag unless buffer full.
// - Only first of two stop bits checked.
// - Framing error loads buffer, full flag stays.
// - No reception while framing flag set.
// - Character done while full sets overrun.
// - Good character loads buffer, sets full flag.
module sre_rx
    import sre_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic rx_line,
    input wire logic hw_standby,
    output logic fifo_in_ready
);
    // Bit period in clock cycles and the half period that centres each
    // sample. The divider is a plain down-counter whose zero count is the
    // one-cycle enable pulse, so no second clock is needed.
    localparam logic [15:0] BIT_CYC = 16'(`SRE_BIT_CYC);
    localparam logic [15:0] HALF_CYC = 16'(`SRE_BIT_CYC / 2);

    sre_rx_state_e state, next_state;
    sre_ctrl_s ctrl, next_ctrl;
    sre_flags_s flags, next_flags;
    logic [15:0] tick_cnt, next_tick_cnt;
    logic [3:0] bit_cnt, next_bit_cnt;
    logic [7:0] rx_shift_register, next_rx_shift_register;
    logic [7:0] rx_holding_buffer, next_rx_holding_buffer;
    // Arms for the read-then-write clear, one per flag.
    logic seen_full, next_seen_full;
    logic seen_ovr, next_seen_ovr;
    logic seen_frm, next_seen_frm;
    logic [31:0] next_prdata;
    logic bit_tick, wr_en, rd_en, char_done, char_good, stop_bad;
    logic sw_clear, rx_blocked;
    logic fifo_push, fifo_pop, fifo_out_valid;
    logic [7:0] fifo_out_data;

    // ----------------------------------------
    // Bus decode
    // ----------------------------------------
    // The slave answers in the first access cycle, so pready is tied high.
    // Zero wait states leave no stall state to get wrong.
    assign pready = 1'b1;
    // Writes and reads act in the access phase only.
    assign wr_en = psel && penable && pwrite;
    assign rd_en = psel && penable && !pwrite;
    // An unmapped or unaligned access errs; a write there changes
    // nothing and a read returns zero.
    assign pslverr = psel && penable && (paddr > `SRE_OFS_FIFO ||
                     paddr[1:0] != 2'b00);
    // Standby pin or bit acts like a reset on the flags and the receiver.
    assign sw_clear = hw_standby || ctrl.standby;
    // While either error flag is up no new start bit is taken; both
    // flags only rise at the end of a character, so none is cut short.
    assign rx_blocked = flags.overrun_flag || flags.framing_flag;

    // ----------------------------------------
    // Receiver timing and framing
    // ----------------------------------------
    // One-cycle enable pulse at the sample point of each bit.
    // The counter reloads at every tick and counts down in between.
    always_comb begin
        bit_tick = (tick_cnt == 16'h0000);
        next_tick_cnt = bit_tick ? 16'(BIT_CYC - 16'h0001) :
                        16'(tick_cnt - 16'h0001);
        next_state = state;
        next_bit_cnt = bit_cnt;
        next_rx_shift_register = rx_shift_register;
        char_done = 1'b0;
        stop_bad = 1'b0;
        case (state)
            SRE_IDLE: begin
                // Preloading half a bit puts the first tick mid start bit.
                next_tick_cnt = HALF_CYC;
                // Hold off a new start bit while an error is pending.
                if (ctrl.rx_enable && !rx_blocked && !rx_line) begin
                    next_state = SRE_START;
                end
            end
            SRE_START: begin
                // A start bit that is high again at its centre was a glitch.
                if (bit_tick) begin
                    next_state = rx_line ? SRE_IDLE : SRE_DATA;
                    next_bit_cnt = 4'h0;
                end
            end
            SRE_DATA: begin
                if (bit_tick) begin
                    // Least significant bit first: shift in at the top.
                    next_rx_shift_register = {rx_line, rx_shift_register[7:1]};
                    next_bit_cnt = 4'(bit_cnt + 4'h1);
                    if (4'(bit_cnt + 4'h1) == `SRE_CHAR_BITS) begin
                        next_state = SRE_STOP1;
                    end
                end
            end
            SRE_STOP1: begin
                // Only a low first stop bit counts as a framing error.
                if (bit_tick) begin
                    char_done = 1'b1;
                    stop_bad = !rx_line;
                    next_state = ctrl.two_stop ? SRE_STOP2 : SRE_IDLE;
                end
            end
            SRE_STOP2: begin
                // Second stop bit is only waited out, never checked.
                if (bit_tick) begin
                    next_state = SRE_IDLE;
                end
            end
            default: next_state = SRE_IDLE;
        endcase
        // Turning reception off aborts a character but keeps flags.
        // A character cut short this way is lost without any error.
        if (!ctrl.rx_enable || sw_clear) begin
            next_state = SRE_IDLE;
        end
    end

    // ----------------------------------------
    // Flags, holding buffer and registers
    // ----------------------------------------
    always_comb begin
        next_ctrl = ctrl;
        next_flags = flags;
        next_rx_holding_buffer = rx_holding_buffer;
        next_seen_full = seen_full;
        next_seen_ovr = seen_ovr;
        next_seen_frm = seen_frm;
        fifo_pop = 1'b0;
        // Overrun wins over framing when the buffer is still full.
        char_good = char_done && !flags.rx_full_flag && !stop_bad;
        // Reads arm the clear sequence for each flag seen as 1. The arm
        // comes from the registered read data, which is what software saw.
        if (rd_en && paddr == `SRE_OFS_STATUS) begin
            next_seen_full = prdata[`SRE_BIT_FULL];
            next_seen_ovr = prdata[`SRE_BIT_OVR];
            next_seen_frm = prdata[`SRE_BIT_FRM];
        end
        // Writing 1 to a flag leaves it alone.
        // A 0 clears only a flag that the last status read showed as 1;
        // a clear without that read is ignored.
        if (wr_en && paddr == `SRE_OFS_STATUS) begin
            if (seen_ovr && !pwdata[`SRE_BIT_OVR]) begin
                next_flags.overrun_flag = 1'b0;
                next_seen_ovr = 1'b0;
            end
            if (seen_frm && !pwdata[`SRE_BIT_FRM]) begin
                next_flags.framing_flag = 1'b0;
                next_seen_frm = 1'b0;
            end
            if (seen_full && !pwdata[`SRE_BIT_FULL]) begin
                next_flags.rx_full_flag = 1'b0;
                next_seen_full = 1'b0;
            end
        end
        // Control bits are plain read/write storage.
        if (wr_en && paddr == `SRE_OFS_CTRL) begin
            next_ctrl.rx_enable = pwdata[`SRE_BIT_RXEN];
            next_ctrl.two_stop = pwdata[`SRE_BIT_STOP2];
            next_ctrl.fifo_enable = pwdata[`SRE_BIT_FEN];
            next_ctrl.standby = pwdata[`SRE_BIT_STBY];
        end
        if (rd_en && paddr == `SRE_OFS_FIFO) begin
            fifo_pop = fifo_out_valid;
        end
        // Hardware events come last so a set wins over a same-cycle clear.
        // Overrun leaves the holding buffer alone; the old character stays.
        if (char_done && flags.rx_full_flag) begin
            next_flags.overrun_flag = 1'b1;
        end else if (char_done && stop_bad) begin
            next_flags.framing_flag = 1'b1;
            next_rx_holding_buffer = rx_shift_register;
        end else if (char_good) begin
            next_rx_holding_buffer = rx_shift_register;
            next_flags.rx_full_flag = 1'b1;
        end
        // Standby acts last and beats every set, just as reset does.
        if (sw_clear) begin
            next_flags = '0;
            next_seen_full = 1'b0;
            next_seen_ovr = 1'b0;
            next_seen_frm = 1'b0;
        end
    end

    // Good characters are copied into the FIFO too when it is enabled.
    // A character with an error never reaches the FIFO, so the FIFO
    // holds only data that software can trust.
    assign fifo_push = char_good && ctrl.fifo_enable;

    // Receiver registers; reset loads constants only.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= SRE_IDLE;
            tick_cnt <= 16'h0000;
            bit_cnt <= 4'h0;
            rx_shift_register <= 8'h00;
        end else begin
            state <= next_state;
            tick_cnt <= next_tick_cnt;
            bit_cnt <= next_bit_cnt;
            rx_shift_register <= next_rx_shift_register;
        end
    end

    // Control, flag and holding buffer registers.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl <= '0;
            flags <= '0;
            rx_holding_buffer <= 8'h00;
            seen_full <= 1'b0;
            seen_ovr <= 1'b0;
            seen_frm <= 1'b0;
        end else begin
            ctrl <= next_ctrl;
            flags <= next_flags;
            rx_holding_buffer <= next_rx_holding_buffer;
            seen_full <= next_seen_full;
            seen_ovr <= next_seen_ovr;
            seen_frm <= next_seen_frm;
        end
    end

    // ----------------------------------------
    // Read data
    // ----------------------------------------
    // Read data is registered in the setup cycle, so prdata is a flop
    // output in the access phase. The price is one cycle of age: a flag
    // set at the setup edge shows only on the next read.
    always_comb begin
        next_prdata = prdata;
        if (psel && !penable && !pwrite) begin
            case (paddr)
                `SRE_OFS_STATUS: next_prdata = {25'h0000000,
                    flags.rx_full_flag, flags.overrun_flag,
                    flags.framing_flag, 4'h0};
                `SRE_OFS_CTRL: next_prdata = {28'h0000000, ctrl.standby,
                    ctrl.fifo_enable, ctrl.two_stop, ctrl.rx_enable};
                `SRE_OFS_DATA: next_prdata = {24'h000000, rx_holding_buffer};
                // An empty FIFO reads as zero, not as stale storage.
                `SRE_OFS_FIFO: next_prdata = {23'h000000, fifo_out_valid,
                    fifo_out_valid ? fifo_out_data : 8'h00};
                default: next_prdata = 32'h00000000;
            endcase
        end
    end

    // Read data holds between reads.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
        end else begin
            prdata <= next_prdata;
        end
    end

    // ----------------------------------------
    // Receive FIFO
    // ----------------------------------------
    // A full FIFO drops characters; the holding buffer still gets them.
    // Standby flushes it with the flags, so no character received before
    // standby can be read from the FIFO after it.
    sre_fifo #(
        .WIDTH(`SRE_DATA_W),
        .DEPTH(`SRE_FIFO_DEPTH)
    ) u_fifo (
        .pclk(pclk),
        .presetn(presetn),
        .flush(sw_clear),
        .in_data(rx_shift_register),
        .in_valid(fifo_push),
        .in_ready(fifo_in_ready),
        .out_data(fifo_out_data),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_pop)
    );
endmodule : sre_rx
`default_nettype wire

// [pkg/sre_cfg.svh]
// Constants for the serial receive error flag block.
`ifndef SRE_CFG_SVH
`define SRE_CFG_SVH
`define SRE_OFS_STATUS 8'h00
`define SRE_OFS_CTRL 8'h04
`define SRE_OFS_DATA 8'h08
`define SRE_OFS_FIFO 8'h0c
`define SRE_BIT_FULL 6
`define SRE_BIT_OVR 5
`define SRE_BIT_FRM 4
`define SRE_BIT_RXEN 0
`define SRE_BIT_STOP2 1
`define SRE_BIT_FEN 2
`define SRE_BIT_STBY 3
`define SRE_BAUD_NS 8680
`define SRE_CLK_NS 100
`define SRE_BIT_CYC ((`SRE_BAUD_NS) / (`SRE_CLK_NS))
`define SRE_FIFO_DEPTH 16
`define SRE_DATA_W 8
`define SRE_CHAR_BITS 4'h8
`endif

// [pkg/sre_pkg.sv]
// Types shared by the serial receive error flag block.
`default_nettype none
package sre_pkg;
    typedef enum logic [2:0] {
        SRE_IDLE, SRE_START, SRE_DATA, SRE_STOP1, SRE_STOP2
    } sre_rx_state_e;
    typedef struct packed {
        logic rx_enable;
        logic two_stop;
        logic fifo_enable;
        logic standby;
    } sre_ctrl_s;
    typedef struct packed {
        logic rx_full_flag;
        logic overrun_flag;
        logic framing_flag;
    } sre_flags_s;
endpackage : sre_pkg
`default_nettype wire

// [sim/serial_rx_error_flags_test.sv]
// Self-checking bench for the serial receiver error flags.
`timescale 1ns/1ps
`default_nettype none
`include "sre_cfg.svh"
module serial_rx_error_flags_test;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic hw_standby, rx_line, fifo_in_ready;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    int n_mismatch = 0;
    int checks = 0;
    logic last_err;
    sre_rx dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .rx_line(rx_line), .hw_standby(hw_standby),
        .fifo_in_ready(fifo_in_ready));
    sre_tx_model tx_u (.pclk(pclk), .rx_line(rx_line));
    // Free-running bus clock.
    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end
    // One bus transfer; the request is held until pready is seen high.
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] wd, output logic [31:0] rd);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        last_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] x;
        apb(1'b1, a, d, x);
    endtask : wr
    task automatic cmp(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask : cmp
    task automatic expect_rd(input string nm, input logic [7:0] a,
                             input logic [31:0] e);
        logic [31:0] g;
        apb(1'b0, a, 32'h0, g);
        cmp(nm, e, g);
    endtask : expect_rd
    task automatic final_report;
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : final_report
    // ----
    // Main sequence
    // ----
    initial begin
        {psel, penable, pwrite, paddr, pwdata, hw_standby, presetn} = '0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        expect_rd("status", 8'h00, 32'h0);
        cmp("pslverr", 32'h0, {31'h0, last_err});
        wr(8'h04, 32'h1);
        tx_u.send(8'ha5, 1'b1, 1'b1);
        expect_rd("status", 8'h00, 32'h40);
        tx_u.send(8'h3c, 1'b1, 1'b1);
        tx_u.send(8'h77, 1'b1, 1'b1);
        expect_rd("data", 8'h08, 32'ha5);
        expect_rd("status", 8'h00, 32'h60);
        wr(8'h00, 32'h20);
        expect_rd("status", 8'h00, 32'h20);
        wr(8'h00, 32'h0);
        expect_rd("status", 8'h00, 32'h0);
        $display("test overrun done");
        // A clear that was not preceded by reading the flag as one.
        tx_u.send(8'h5a, 1'b0, 1'b1);
        wr(8'h00, 32'h0);
        expect_rd("status", 8'h00, 32'h10);
        tx_u.send(8'h81, 1'b1, 1'b1);
        wr(8'h04, 32'h0);
        expect_rd("data", 8'h08, 32'h5a);
        expect_rd("status", 8'h00, 32'h10);
        wr(8'h00, 32'h0);
        expect_rd("status", 8'h00, 32'h0);
        wr(8'h04, 32'h3);
        tx_u.send(8'hc3, 1'b1, 1'b0);
        expect_rd("status", 8'h00, 32'h40);
        $display("test framing done");
        wr(8'h04, 32'h8);
        expect_rd("status", 8'h00, 32'h0);
        wr(8'h04, 32'h1);
        tx_u.send(8'h66, 1'b0, 1'b1);
        // Read while the pin is still high, one cycle into standby.
        hw_standby <= 1'b1;
        expect_rd("status", 8'h00, 32'h0);
        hw_standby <= 1'b0;
        expect_rd("status", 8'h00, 32'h0);
        $display("test standby done");
        // Fill the buffer until it refuses, then drain it empty.
        wr(8'h04, 32'h5);
        for (int i = 0; i < `SRE_FIFO_DEPTH; i++) begin
            tx_u.send(8'(i + 16), 1'b1, 1'b1);
            // Free the holding buffer so the next one is no overrun.
            expect_rd("status", 8'h00, 32'h40);
            wr(8'h00, 32'h0);
        end
        expect_rd("data", 8'h08, 32'h1f);
        @(negedge pclk);
        cmp("in_ready", 32'h0, {31'h0, fifo_in_ready});
        for (int i = 0; i < `SRE_FIFO_DEPTH; i++) begin
            expect_rd("fifo", 8'h0c, 32'h100 | 32'(i + 16));
        end
        expect_rd("fifo", 8'h0c, 32'h0);
        expect_rd("unmapped", 8'h10, 32'h0);
        cmp("pslverr", 32'h1, {31'h0, last_err});
        $display("test fifo done");
        final_report();
    end
    // A hang counts against the run and ends it the normal way.
    initial begin
        repeat (60000) @(posedge pclk);
        n_mismatch++;
        final_report();
    end
endmodule : serial_rx_error_flags_test
bind sre_rx sre_rx_props chk_u (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .hw_standby(hw_standby));
`default_nettype wire

// [sim/sre_rx_props.sv]
// Concurrent checks on the bus side of the serial receiver.
`timescale 1ns/1ps
`default_nettype none
module sre_rx_props (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic hw_standby
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // Bus phase decodes; a bad address is unmapped or unaligned.
    logic rd_setup;
    logic access;
    logic bad;
    assign rd_setup = psel && !penable && !pwrite;
    assign access = psel && penable;
    assign bad = (paddr > 8'h0c) || (paddr[1:0] != 2'b00);
    chk_ready_high: assert property (pready)
        else $error("pready low");
    chk_err_bad: assert property (access && bad |-> pslverr)
        else $error("no error on bad address");
    chk_err_good: assert property (access && !bad |-> !pslverr)
        else $error("error on mapped address");
    chk_bad_zero: assert property (access && !pwrite && bad |-> prdata == 0)
        else $error("bad read not zero");
    chk_data_hold: assert property (!rd_setup |=> $stable(prdata))
        else $error("read data moved outside read setup");
    chk_status_bits: assert property (access && !pwrite && paddr == 8'h00
        |-> prdata[31:7] == 0 && prdata[3:0] == 0)
        else $error("stray status bits");
    chk_reset_zero: assert property ($rose(presetn) |-> prdata == 0)
        else $error("read data not zero after reset");
    chk_standby_clr: assert property (rd_setup && paddr == 8'h00
        && $past(hw_standby) |=> prdata[5:4] == 2'b00)
        else $error("error flags survive standby");
endmodule : sre_rx_props
`default_nettype wire

// [sim/sre_tx_model.sv]
// Behavioural remote transmitter that drives the serial receive line.
`timescale 1ns/1ps
`default_nettype none
`include "sre_cfg.svh"
module sre_tx_model (
    input wire logic pclk,
    output logic rx_line
);
    // The line idles high between frames, as its pull-up would hold it.
    initial rx_line = 1'b1;
    // Each bit is held a whole bit period, changed just after an edge.
    task automatic put_bit(input logic b);
        rx_line <= b;
        repeat (`SRE_BIT_CYC) @(posedge pclk);
    endtask : put_bit
    // Start bit, eight data bits LSB first, two stop slots, then idle.
    task automatic send(input logic [7:0] d, input logic s1,
                        input logic s2);
        @(posedge pclk);
        put_bit(1'b0);
        for (int i = 0; i < 8; i++) put_bit(d[i]);
        put_bit(s1);
        put_bit(s2);
        put_bit(1'b1);
        put_bit(1'b1);
    endtask : send
endmodule : sre_tx_model
`default_nettype wire
